// ==== shared/osp_pkg.sv ====
// Purpose: Shared constants for the oscillator select and PLL translation block
// Assumes: AXI4-Lite register access, 32-bit data, 12-bit byte address
// Notes:   Crystal code table gives a PLL target near 400 MHz

package osp_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] RUN_CLOCK_CONFIG_OFF = 12'h060;
    localparam logic [11:0] PLL_TRANSLATION_OFF = 12'h064;

    // ------------------------------------------------------------
    // Run clock config field positions
    // ------------------------------------------------------------
    localparam int MAIN_OSC_OFF_BIT = 0;
    localparam int INTERNAL_OSC_OFF_BIT = 1;
    localparam int OSC_SRC_LSB = 4;
    localparam int OSC_SRC_MSB = 5;
    localparam int CRYSTAL_LSB = 6;
    localparam int CRYSTAL_MSB = 9;

    // ------------------------------------------------------------
    // PLL translation field positions
    // ------------------------------------------------------------
    localparam int PLL_DIV_LSB = 0;
    localparam int PLL_DIV_MSB = 4;
    localparam int PLL_MULT_LSB = 5;
    localparam int PLL_MULT_MSB = 13;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CRYSTAL_RESET = 4'hb;
    localparam logic [1:0] OSC_SRC_RESET = 2'h1;
    localparam logic INTERNAL_OSC_OFF_RESET = 1'b0;
    localparam logic MAIN_OSC_OFF_RESET = 1'b1;

    // ------------------------------------------------------------
    // Oscillator source encodings
    // ------------------------------------------------------------
    localparam logic [1:0] OSC_SRC_MAIN = 2'h0;
    localparam logic [1:0] OSC_SRC_INTERNAL = 2'h1;
    localparam logic [1:0] OSC_SRC_INTERNAL_DIV4 = 2'h2;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Translation table, entry = {multiplier[8:0], divider[4:0]}
    // ------------------------------------------------------------
    // Reserved codes 0..3 translate to zero: the PLL must not be used with them
    localparam logic [13:0] XLAT_TABLE [16] = '{
        14'h0000, 14'h0000, 14'h0000, 14'h0000,
        14'h0e00, 14'h0d80, 14'h1901, 14'h1861,
        14'h1461, 14'h3204, 14'h1381, 14'h1902,
        14'h1862, 14'h1462, 14'h1903, 14'h1863
    };

    typedef enum logic [1:0] {
        OSP_WR_COLLECT = 2'b01,
        OSP_WR_RESP = 2'b10
    } osp_wr_state_e;

    typedef enum logic [1:0] {
        OSP_RD_IDLE = 2'b01,
        OSP_RD_RESP = 2'b10
    } osp_rd_state_e;

endpackage

// ==== design/osp_xlat_rom.sv ====
// Purpose: Crystal code to PLL multiplier and divider lookup
// Assumes: Code input is stable or changes only on clock edges
// Notes:   Read data are registered, one cycle from code to data

`timescale 1ns/1ps

module osp_xlat_rom (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] code,
    output logic [13:0] entry
);

    typedef struct packed {
        logic [13:0] entry;
    } osp_rom_s;

    osp_rom_s state_ff;
    osp_rom_s nxt_state;

    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.entry = osp_pkg::XLAT_TABLE[code]; // [R10]
    end

    // Reset loads the entry of the reset crystal code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff.entry <= osp_pkg::XLAT_TABLE[osp_pkg::CRYSTAL_RESET]; // [R6]
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign entry = state_ff.entry;

endmodule

// ==== design/osp_clock_sel.sv ====
// Purpose: Oscillator source select and crystal to PLL translation registers
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes:   Upper clock fields live elsewhere and read as zero here

`timescale 1ns/1ps

// Operation
// [R1] Crystal code 4..F valid, resets to 0xB
// [R2] Source select bits 5:4, resets to internal
// [R3] Internal oscillator off bit 1, resets 0
// [R4] Main oscillator off bit 0, resets 1
// [R5] Bits 3:2 always read zero
// [R6] Translation loaded at reset, reloaded on change
// [R7] PLL output is osc times mult over div+1
// [R8] Translation read-only: mult 13:5, div 4:0
// [R9] Crystal code bits 9:6, writable, resets 0xB
// [R10] Multiplier and divider from fixed lookup table
module osp_clock_sel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] crystal_freq_code,
    output logic [1:0] osc_src_sel,
    output logic internal_osc_off,
    output logic main_osc_off,
    output logic [8:0] pll_mult,
    output logic [4:0] pll_div
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        osp_pkg::osp_wr_state_e wr_state;
        osp_pkg::osp_rd_state_e rd_state;
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] crystal;
        logic [1:0] osc_src;
        logic int_osc_off;
        logic main_osc_off;
        logic [8:0] mult;
        logic [4:0] div;
    } osp_state_s;

    osp_state_s state_ff;
    osp_state_s nxt_state;

    logic [13:0] xlat_entry;

    // ------------------------------------------------------------
    // Translation lookup
    // ------------------------------------------------------------
    // The table follows the stored crystal code every cycle, so any write that
    // changes the code reloads the translation without a separate trigger.
    osp_xlat_rom u_xlat_rom (
        .aclk(aclk),
        .aresetn(aresetn),
        .code(state_ff.crystal),
        .entry(xlat_entry)
    );

    // ------------------------------------------------------------
    // Register image helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] run_clock_image(input osp_state_s s);
        logic [31:0] img;
        img = 32'h0000_0000; // [R5]
        img[osp_pkg::CRYSTAL_MSB:osp_pkg::CRYSTAL_LSB] = s.crystal; // [R9]
        img[osp_pkg::OSC_SRC_MSB:osp_pkg::OSC_SRC_LSB] = s.osc_src; // [R2]
        img[osp_pkg::INTERNAL_OSC_OFF_BIT] = s.int_osc_off; // [R3]
        img[osp_pkg::MAIN_OSC_OFF_BIT] = s.main_osc_off; // [R4]
        return img;
    endfunction

    function automatic logic [31:0] pll_image(input osp_state_s s);
        logic [31:0] img;
        img = 32'h0000_0000; // [R8]
        img[osp_pkg::PLL_MULT_MSB:osp_pkg::PLL_MULT_LSB] = s.mult; // [R8]
        img[osp_pkg::PLL_DIV_MSB:osp_pkg::PLL_DIV_LSB] = s.div; // [R8]
        return img;
    endfunction

    // Only the word index is compared, so byte offsets inside a register alias to it.
    // One-hot result: bit 0 run clock config, bit 1 translation, none when unmapped.
    function automatic logic [1:0] decode_addr(input logic [11:0] addr);
        logic [1:0] hit;
        hit = 2'b00;
        if (addr[11:2] == osp_pkg::RUN_CLOCK_CONFIG_OFF[11:2]) begin
            hit = 2'b01;
        end else if (addr[11:2] == osp_pkg::PLL_TRANSLATION_OFF[11:2]) begin
            hit = 2'b10;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic have_aw;
        logic have_w;
        logic [11:0] wr_addr;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
        logic [31:0] merged;
        logic [31:0] bitmask;
        logic [1:0] wr_hit;
        logic [1:0] rd_hit;
        have_aw = 1'b0;
        have_w = 1'b0;
        wr_addr = 12'h000;
        wr_data = 32'h0000_0000;
        wr_strb = 4'h0;
        merged = 32'h0000_0000;
        bitmask = 32'h0000_0000;
        wr_hit = 2'b00;
        rd_hit = 2'b00;
        nxt_state = state_ff;

        // Translation tracks the lookup output; software cannot write it
        nxt_state.mult = xlat_entry[13:5]; // [R6] [R7]
        nxt_state.div = xlat_entry[4:0]; // [R6] [R7]

        // Write channel
        case (state_ff.wr_state)
            osp_pkg::OSP_WR_COLLECT: begin
                have_aw = state_ff.aw_got || (s_axi_awvalid && state_ff.awready);
                have_w = state_ff.w_got || (s_axi_wvalid && state_ff.wready);
                wr_addr = state_ff.aw_got ? state_ff.aw_addr : s_axi_awaddr;
                wr_data = state_ff.w_got ? state_ff.w_data : s_axi_wdata;
                wr_strb = state_ff.w_got ? state_ff.w_strb : s_axi_wstrb;
                if (s_axi_awvalid && state_ff.awready) begin
                    nxt_state.aw_got = 1'b1;
                    nxt_state.aw_addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && state_ff.wready) begin
                    nxt_state.w_got = 1'b1;
                    nxt_state.w_data = s_axi_wdata;
                    nxt_state.w_strb = s_axi_wstrb;
                end
                if (have_aw && have_w) begin
                    nxt_state.aw_got = 1'b0;
                    nxt_state.w_got = 1'b0;
                    nxt_state.bvalid = 1'b1;
                    nxt_state.wr_state = osp_pkg::OSP_WR_RESP;
                    nxt_state.bresp = osp_pkg::RESP_OKAY;
                    // Byte enables decide which stored bits a write may touch
                    for (int b = 0; b < 4; b++) begin
                        bitmask[b*8 +: 8] = {8{wr_strb[b]}};
                    end
                    merged = (wr_data & bitmask) | (run_clock_image(state_ff) & ~bitmask);
                    wr_hit = decode_addr(wr_addr);
                    if (wr_hit[0]) begin
                        nxt_state.crystal = merged[osp_pkg::CRYSTAL_MSB:osp_pkg::CRYSTAL_LSB]; // [R9] [R1]
                        nxt_state.osc_src = merged[osp_pkg::OSC_SRC_MSB:osp_pkg::OSC_SRC_LSB]; // [R2]
                        nxt_state.int_osc_off = merged[osp_pkg::INTERNAL_OSC_OFF_BIT]; // [R3]
                        nxt_state.main_osc_off = merged[osp_pkg::MAIN_OSC_OFF_BIT]; // [R4]
                    end else if (wr_hit[1]) begin
                        // Read-only: the write is accepted and dropped
                        nxt_state.bresp = osp_pkg::RESP_OKAY; // [R8]
                    end else begin
                        nxt_state.bresp = osp_pkg::RESP_SLVERR;
                    end
                end
            end
            osp_pkg::OSP_WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_state.bvalid = 1'b0;
                    nxt_state.wr_state = osp_pkg::OSP_WR_COLLECT;
                end
            end
            default: begin
                // A corrupted state code falls back to collecting with nothing pending
                nxt_state.wr_state = osp_pkg::OSP_WR_COLLECT;
                nxt_state.bresp = osp_pkg::RESP_OKAY;
                nxt_state.bvalid = 1'b0;
                nxt_state.aw_got = 1'b0;
                nxt_state.w_got = 1'b0;
            end
        endcase

        // Each ready drops while its own half is held or a response is pending
        nxt_state.awready = (nxt_state.wr_state == osp_pkg::OSP_WR_COLLECT) && !nxt_state.aw_got;
        nxt_state.wready = (nxt_state.wr_state == osp_pkg::OSP_WR_COLLECT) && !nxt_state.w_got;

        // Read channel
        case (state_ff.rd_state)
            osp_pkg::OSP_RD_IDLE: begin
                if (s_axi_arvalid && state_ff.arready) begin
                    nxt_state.rvalid = 1'b1;
                    nxt_state.arready = 1'b0;
                    nxt_state.rd_state = osp_pkg::OSP_RD_RESP;
                    nxt_state.rresp = osp_pkg::RESP_OKAY;
                    rd_hit = decode_addr(s_axi_araddr);
                    if (rd_hit[0]) begin
                        nxt_state.rdata = run_clock_image(state_ff); // [R5]
                    end else if (rd_hit[1]) begin
                        nxt_state.rdata = pll_image(state_ff); // [R8]
                    end else begin
                        nxt_state.rdata = 32'h0000_0000;
                        nxt_state.rresp = osp_pkg::RESP_SLVERR;
                    end
                end
            end
            osp_pkg::OSP_RD_RESP: begin
                if (s_axi_rready) begin
                    nxt_state.rvalid = 1'b0;
                    nxt_state.arready = 1'b1;
                    nxt_state.rd_state = osp_pkg::OSP_RD_IDLE;
                end
            end
            default: begin
                // Same recovery as the write side: idle, no stale read data kept
                nxt_state.rd_state = osp_pkg::OSP_RD_IDLE;
                nxt_state.rdata = 32'h0000_0000;
                nxt_state.rresp = osp_pkg::RESP_OKAY;
                nxt_state.rvalid = 1'b0;
                nxt_state.arready = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff.wr_state <= osp_pkg::OSP_WR_COLLECT;
            state_ff.rd_state <= osp_pkg::OSP_RD_IDLE;
            state_ff.aw_got <= 1'b0;
            state_ff.aw_addr <= 12'h000;
            state_ff.w_got <= 1'b0;
            state_ff.w_data <= 32'h0000_0000;
            state_ff.w_strb <= 4'h0;
            state_ff.awready <= 1'b1;
            state_ff.wready <= 1'b1;
            state_ff.bvalid <= 1'b0;
            state_ff.bresp <= osp_pkg::RESP_OKAY;
            state_ff.arready <= 1'b1;
            state_ff.rvalid <= 1'b0;
            state_ff.rdata <= 32'h0000_0000;
            state_ff.rresp <= osp_pkg::RESP_OKAY;
            state_ff.crystal <= osp_pkg::CRYSTAL_RESET; // [R1] [R9]
            state_ff.osc_src <= osp_pkg::OSC_SRC_RESET; // [R2]
            state_ff.int_osc_off <= osp_pkg::INTERNAL_OSC_OFF_RESET; // [R3]
            state_ff.main_osc_off <= osp_pkg::MAIN_OSC_OFF_RESET; // [R4]
            // Reset sequence loads the translation of the reset crystal code
            state_ff.mult <= osp_pkg::XLAT_TABLE[osp_pkg::CRYSTAL_RESET][13:5]; // [R6]
            state_ff.div <= osp_pkg::XLAT_TABLE[osp_pkg::CRYSTAL_RESET][4:0]; // [R6]
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = state_ff.awready;
    assign s_axi_wready = state_ff.wready;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_arready = state_ff.arready;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;
    assign crystal_freq_code = state_ff.crystal;
    assign osc_src_sel = state_ff.osc_src;
    assign internal_osc_off = state_ff.int_osc_off;
    assign main_osc_off = state_ff.main_osc_off;
    assign pll_mult = state_ff.mult; // [R7]
    assign pll_div = state_ff.div; // [R7]

endmodule

// ==== tb/osp_clock_sel_sva.sv ====
// Purpose: Assertions on the oscillator select and PLL translation ports
// Assumes: The master offers write address and write data together
// Notes:   Bound to every osp_clock_sel instance
`timescale 1ns/1ps

module osp_clock_sel_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [3:0] crystal_freq_code,
    input wire logic [1:0] osc_src_sel,
    input wire logic internal_osc_off,
    input wire logic main_osc_off,
    input wire logic [8:0] pll_mult,
    input wire logic [4:0] pll_div
);
    logic wr_all;
    logic rd_go;
    assign wr_all = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == osp_pkg::RUN_CLOCK_CONFIG_OFF;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_vals:
        assert property ($rose(aresetn) |-> crystal_freq_code == 4'hb && osc_src_sel == 2'h1
            && !internal_osc_off && main_osc_off) else $error("reset values wrong");
    a_field_wr:
        assert property (wr_all && s_axi_wstrb[0] |=> osc_src_sel == $past(s_axi_wdata[5:4])
            && internal_osc_off == $past(s_axi_wdata[1]) && main_osc_off == $past(s_axi_wdata[0]))
            else $error("select or off bits not written");
    a_code_wr:
        assert property (wr_all && s_axi_wstrb[1:0] == 2'h3 |=> crystal_freq_code == $past(s_axi_wdata[9:6]))
            else $error("crystal code not written");
    a_cfg_hold:
        assert property (!$rose(s_axi_bvalid) |-> $stable({crystal_freq_code, osc_src_sel,
            internal_osc_off, main_osc_off})) else $error("config moved without a write");
    a_xlat_lag:
        assert property ({pll_mult, pll_div} == osp_pkg::XLAT_TABLE[$past(crystal_freq_code, 2)])
            else $error("translation does not follow crystal code");
    a_wr_answer:
        assert property (wr_all |=> s_axi_bvalid && s_axi_bresp == osp_pkg::RESP_OKAY)
            else $error("config write not answered okay");
    a_rd_cfg:
        assert property (rd_go && s_axi_araddr == osp_pkg::RUN_CLOCK_CONFIG_OFF |=> s_axi_rvalid
            && s_axi_rdata == {22'h0, $past(crystal_freq_code), $past(osc_src_sel), 2'h0,
            $past(internal_osc_off), $past(main_osc_off)}) else $error("config read image wrong");
    a_rd_xlat:
        assert property (rd_go && s_axi_araddr == osp_pkg::PLL_TRANSLATION_OFF |=> s_axi_rvalid
            && s_axi_rdata == {18'h0, $past(pll_mult), $past(pll_div)}) else $error("translation read wrong");

    c_code_wr: cover property (wr_all && s_axi_wstrb == 4'hf);
    c_rd_xlat: cover property (rd_go && s_axi_araddr == osp_pkg::PLL_TRANSLATION_OFF);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == osp_pkg::RESP_SLVERR);
endmodule

bind osp_clock_sel osp_clock_sel_sva u_osp_clock_sel_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .crystal_freq_code(crystal_freq_code),
    .osc_src_sel(osc_src_sel), .internal_osc_off(internal_osc_off), .main_osc_off(main_osc_off),
    .pll_mult(pll_mult), .pll_div(pll_div));

// ==== tb/osp_clock_sel_tb_top.sv ====
// Purpose: Self-checking bench for the oscillator select and translation block
// Assumes: Single AXI4-Lite master, one transfer at a time
// Notes:   Translation read waits past the two-cycle reload lag
`timescale 1ns/1ps

module osp_clock_sel_tb_top;
    typedef struct packed {logic [31:0] wdata; logic [31:0] img;} osp_row_s;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic internal_osc_off, main_osc_off;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb, crystal_freq_code;
    logic [1:0] s_axi_bresp, s_axi_rresp, osc_src_sel;
    logic [8:0] pll_mult;
    logic [4:0] pll_div;
    int num_errors, cmp_count;
    // Junk in bits 3:2 and above bit 9 must never show in the image
    osp_row_s rows [7] = '{'{32'h0000_0100, 32'h0000_0100}, '{32'hffff_ffff, 32'h0000_03f3},
        '{32'h0000_026e, 32'h0000_0262}, '{32'h0000_0295, 32'h0000_0291},
        '{32'h8000_02dc, 32'h0000_02d0}, '{32'h0000_0361, 32'h0000_0361},
        '{32'h0000_03a2, 32'h0000_03a2}};

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    osp_clock_sel u_osp_clock_sel (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .crystal_freq_code(crystal_freq_code), .osc_src_sel(osc_src_sel),
        .internal_osc_off(internal_osc_off), .main_osc_off(main_osc_off),
        .pll_mult(pll_mult), .pll_div(pll_div));

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            num_errors++;
            conclude();
        end
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [11:0] a, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            num_errors++;
            conclude();
        end
        rd_data = s_axi_rdata;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // Write the config word, read it back, then look at the pins
    task automatic wrrd(input logic [31:0] d, input logic [3:0] s, input logic [31:0] img);
        wr(osp_pkg::RUN_CLOCK_CONFIG_OFF, d, s, osp_pkg::RESP_OKAY);
        rd(osp_pkg::RUN_CLOCK_CONFIG_OFF, osp_pkg::RESP_OKAY);
        chk("cfg_read", img, rd_data);
        chk("cfg_pins", img, {22'h0, crystal_freq_code, osc_src_sel, 2'h0, internal_osc_off, main_osc_off});
        chk("pll_pins", {18'h0, osp_pkg::XLAT_TABLE[img[9:6]]}, {18'h0, pll_mult, pll_div});
    endtask

    task automatic chk_rst();
        rd(osp_pkg::RUN_CLOCK_CONFIG_OFF, osp_pkg::RESP_OKAY);
        chk("cfg_reset", 32'h0000_02d1, rd_data);
        rd(osp_pkg::PLL_TRANSLATION_OFF, osp_pkg::RESP_OKAY);
        chk("xlat_reset", {18'h0, osp_pkg::XLAT_TABLE[4'hb]}, rd_data);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        num_errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_rst();
        foreach (rows[i]) wrrd(rows[i].wdata, 4'hf, rows[i].img);
        for (int c = 0; c < 16; c++) begin
            wrrd({22'h0, c[3:0], 6'h11}, 4'hf, {22'h0, c[3:0], 6'h11});
            rd(osp_pkg::PLL_TRANSLATION_OFF, osp_pkg::RESP_OKAY);
            chk("xlat", {18'h0, osp_pkg::XLAT_TABLE[c]}, rd_data);
        end
        // Single byte lanes: code straddles both, so each lane moves only its half
        wrrd(32'h0000_0000, 4'h2, 32'h0000_00d1);
        wrrd(32'hffff_ff2e, 4'h1, 32'h0000_0022);
        wr(osp_pkg::PLL_TRANSLATION_OFF, 32'hffff_ffff, 4'hf, osp_pkg::RESP_OKAY);
        rd(osp_pkg::PLL_TRANSLATION_OFF, osp_pkg::RESP_OKAY);
        chk("xlat_ro", {18'h0, osp_pkg::XLAT_TABLE[0]}, rd_data);
        wr(12'h068, 32'hffff_ffff, 4'hf, osp_pkg::RESP_SLVERR);
        rd(12'h068, osp_pkg::RESP_SLVERR);
        chk("unmapped", 32'h0, rd_data);
        rd(osp_pkg::RUN_CLOCK_CONFIG_OFF, osp_pkg::RESP_OKAY);
        chk("cfg_kept", 32'h0000_0022, rd_data);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_rst();
        conclude();
    end
endmodule
